/* File: radio_pkg.sv */
// constants and functions shared by the radio register bank and its host controller
// How it works
// - host writes zero to reserved bits
// - write gate set: gated registers accept writes
// - write gate clear: gated registers ignore writes
// - identifier bytes readable only while enabled
// - host enables identifier reads only briefly; a direct analog_control write can leave the enable set
// - amp enable bit drives amp pin
// - polarity bit selects amp pin level
// - host never changes enable and polarity together, except when a soft reset write clears both at once
// - writing one to bit zero resets, self-clears
// - soft reset restores every register default
// - channel field sets synthesizer frequency
// - adjacent channels differ by one megahertz
// - host programs only channels two to 79
// - host permits the first transmit once a valid channel write is accepted, two cycles before the write lands
package radio_pkg;

  // device register offsets
  localparam logic [7:0] ANALOG_CONTROL_OFS = 8'h20;
  localparam logic [7:0] CHANNEL_SELECT_OFS = 8'h21;
  localparam logic [7:0] GATED_LO_OFS       = 8'h2e;
  localparam logic [7:0] GATED_HI_OFS       = 8'h2f;
  localparam logic [7:0] ID_FIRST_OFS       = 8'h3c;
  localparam logic [7:0] ID_LAST_OFS        = 8'h3f;

  // analog_control field positions
  localparam int WRITE_GATE_BIT = 6;
  localparam int ID_ENABLE_BIT  = 5;
  localparam int AMP_ENABLE_BIT = 2;
  localparam int AMP_POL_BIT    = 1;
  localparam int SOFT_RESET_BIT = 0;

  // writable bits; everything else is reserved
  localparam logic [7:0] ANALOG_WRITABLE_MASK = 8'h67;
  localparam logic [7:0] ANALOG_STORED_MASK   = 8'h66;
  localparam logic [7:0] CHANNEL_WRITABLE_MASK = 8'h7f;

  // values after reset
  localparam logic [7:0] ANALOG_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CHANNEL_SELECT_RESET = 8'h00;
  localparam logic [7:0] GATED_RESET          = 8'h00;

  // synthesizer mapping: channel n lands at base + n * step
  localparam logic [6:0]  CHANNEL_MIN   = 7'h02;
  localparam logic [6:0]  CHANNEL_MAX   = 7'h4f;
  localparam logic [11:0] FREQ_BASE_MHZ = 12'h960;
  localparam logic [11:0] FREQ_STEP_MHZ = 12'h001;

  // host controller register map (avalon byte addresses)
  localparam logic [3:0] HOST_COMMAND_OFS = 4'h0;
  localparam logic [3:0] HOST_STATUS_OFS  = 4'h4;
  localparam int CMD_ADDR_LSB  = 0;
  localparam int CMD_DATA_LSB  = 8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int STAT_BUSY_BIT      = 0;
  localparam int STAT_CHAN_DONE_BIT = 1;
  localparam int STAT_CHAN_ERR_BIT  = 2;
  localparam int STAT_RDATA_LSB     = 8;

  function automatic logic [11:0] channel_to_mhz(input logic [6:0] chan);
    channel_to_mhz = FREQ_BASE_MHZ + ({5'h00, chan} * FREQ_STEP_MHZ);
  endfunction

  function automatic logic in_id_range(input logic [7:0] addr);
    in_id_range = (addr >= ID_FIRST_OFS) && (addr <= ID_LAST_OFS);
  endfunction

endpackage

/* File: radio_reg_if.sv */
// register access port between the host controller and the radio register bank
`timescale 1ns/10ps
interface radio_reg_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       rvalid;

  modport host (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata,
    input  rvalid
  );

  modport device (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata,
    output rvalid
  );
endinterface

/* File: radio_regs.sv */
// radio register bank: analog control and channel select, device end
`timescale 1ns/10ps
module radio_regs (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  radio_reg_if.device      bus,
  input  wire logic [29:0] id_word_i,
  input  wire logic        amp_request_i,
  output logic             amp_control_pin_o,
  output logic             amp_control_pin_oe_o,
  output logic             id_power_o,
  output logic             soft_reset_o,
  output logic [6:0]       channel_o,
  output logic [11:0]      freq_mhz_o,
  output logic [7:0]       gated_lo_o,
  output logic [7:0]       gated_hi_o
);

  typedef struct packed {
    logic        write_gate;
    logic        id_enable;
    logic        amp_output_enable;
    logic        amp_polarity_select;
    logic [6:0]  channel;
    logic [11:0] freq_mhz;
    logic [7:0]  gated_lo;
    logic [7:0]  gated_hi;
    logic [7:0]  rdata;
    logic        rvalid;
    logic        soft_reset;
    logic        amp_pin;
  } dev_state_t;

  dev_state_t state_reg;
  dev_state_t state_next;

  // every register default in one place, used by soft reset; hard reset clears state_reg to zero
  function automatic dev_state_t default_state();
    dev_state_t d;
    d                     = '0;
    d.write_gate          = radio_pkg::ANALOG_CONTROL_RESET[radio_pkg::WRITE_GATE_BIT];
    d.id_enable           = radio_pkg::ANALOG_CONTROL_RESET[radio_pkg::ID_ENABLE_BIT];
    d.amp_output_enable   = radio_pkg::ANALOG_CONTROL_RESET[radio_pkg::AMP_ENABLE_BIT];
    d.amp_polarity_select = radio_pkg::ANALOG_CONTROL_RESET[radio_pkg::AMP_POL_BIT];
    d.channel             = radio_pkg::CHANNEL_SELECT_RESET[6:0];
    d.freq_mhz            = radio_pkg::channel_to_mhz(radio_pkg::CHANNEL_SELECT_RESET[6:0]);
    d.gated_lo            = radio_pkg::GATED_RESET;
    d.gated_hi            = radio_pkg::GATED_RESET;
    return d;
  endfunction

  // soft reset bit is never stored, so it always reads back zero
  function automatic logic [7:0] analog_readback(input dev_state_t s);
    logic [7:0] v;
    v                                 = 8'h00;
    v[radio_pkg::WRITE_GATE_BIT]      = s.write_gate;
    v[radio_pkg::ID_ENABLE_BIT]       = s.id_enable;
    v[radio_pkg::AMP_ENABLE_BIT]      = s.amp_output_enable;
    v[radio_pkg::AMP_POL_BIT]         = s.amp_polarity_select;
    return v;
  endfunction

  function automatic logic [7:0] id_byte(input logic [29:0] id, input logic [1:0] idx);
    logic [31:0] w;
    w = {2'b00, id};
    case (idx)
      2'h0:    id_byte = w[7:0];
      2'h1:    id_byte = w[15:8];
      2'h2:    id_byte = w[23:16];
      default: id_byte = w[31:24];
    endcase
  endfunction

  always_comb begin
    logic [7:0] rd_value;
    rd_value = 8'h00;
    state_next = state_reg;
    state_next.rvalid     = 1'b0;
    state_next.soft_reset = 1'b0;

    if (bus.wr) begin
      case (bus.addr)
        radio_pkg::ANALOG_CONTROL_OFS: begin
          if (bus.wdata[radio_pkg::SOFT_RESET_BIT]) begin
            // a reset write discards the other bits of the same write
            state_next            = default_state();
            state_next.soft_reset = 1'b1;
          end else begin
            // reserved positions 7, 4 and 3 are simply not stored
            state_next.write_gate          = bus.wdata[radio_pkg::WRITE_GATE_BIT];
            state_next.id_enable           = bus.wdata[radio_pkg::ID_ENABLE_BIT];
            state_next.amp_output_enable   = bus.wdata[radio_pkg::AMP_ENABLE_BIT];
            state_next.amp_polarity_select = bus.wdata[radio_pkg::AMP_POL_BIT];
          end
        end
        radio_pkg::CHANNEL_SELECT_OFS: begin
          state_next.channel  = bus.wdata[6:0];
          state_next.freq_mhz = radio_pkg::channel_to_mhz(bus.wdata[6:0]);
        end
        radio_pkg::GATED_LO_OFS: begin
          if (state_reg.write_gate) begin
            state_next.gated_lo = bus.wdata;
          end
        end
        radio_pkg::GATED_HI_OFS: begin
          if (state_reg.write_gate) begin
            state_next.gated_hi = bus.wdata;
          end
        end
        default: begin
        end
      endcase
    end

    if (bus.rd) begin
      if (bus.addr == radio_pkg::ANALOG_CONTROL_OFS) begin
        rd_value = analog_readback(state_reg);
      end else if (bus.addr == radio_pkg::CHANNEL_SELECT_OFS) begin
        rd_value = {1'b0, state_reg.channel};
      end else if (bus.addr == radio_pkg::GATED_LO_OFS) begin
        rd_value = state_reg.gated_lo;
      end else if (bus.addr == radio_pkg::GATED_HI_OFS) begin
        rd_value = state_reg.gated_hi;
      end else if (radio_pkg::in_id_range(bus.addr) && state_reg.id_enable) begin
        rd_value = id_byte(id_word_i, bus.addr[1:0]);
      end else begin
        rd_value = 8'h00;
      end
      state_next.rvalid = 1'b1;
      state_next.rdata  = rd_value;
    end

    // pin follows the request, flipped when active low is chosen
    if (state_next.amp_output_enable) begin
      state_next.amp_pin = amp_request_i ^ state_next.amp_polarity_select;
    end else begin
      state_next.amp_pin = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus.rdata            = state_reg.rdata;
  assign bus.rvalid           = state_reg.rvalid;
  assign amp_control_pin_o    = state_reg.amp_pin;
  assign amp_control_pin_oe_o = state_reg.amp_output_enable;
  // the identifier block burns power only while this is high
  assign id_power_o           = state_reg.id_enable;
  assign soft_reset_o         = state_reg.soft_reset;
  assign channel_o            = state_reg.channel;
  assign freq_mhz_o           = state_reg.freq_mhz;
  assign gated_lo_o           = state_reg.gated_lo;
  assign gated_hi_o           = state_reg.gated_hi;

endmodule

/* File: radio_host.sv */
// host controller: avalon-mm command registers driving the radio register port
`timescale 1ns/10ps
module radio_host (
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  output logic             tx_permit_o,
  radio_reg_if.host        bus
);

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_ISSUE,
    PH_WAIT
  } phase_t;

  typedef struct packed {
    phase_t          phase;
    logic [2:0][7:0] step_addr;
    logic [2:0][7:0] step_data;
    logic [2:0]      step_wr;
    logic [1:0]      step_last;
    logic [1:0]      step_idx;
    logic [7:0]      analog_shadow;
    logic            chan_done;
    logic            chan_error;
    logic [7:0]      last_rdata;
    logic            rd_ack;
    logic [31:0]     readdata;
    logic [7:0]      bus_addr;
    logic [7:0]      bus_wdata;
    logic            bus_wr;
    logic            bus_rd;
  } host_state_t;

  host_state_t state_reg;
  host_state_t state_next;

  function automatic host_state_t put_step(input host_state_t s, input logic [1:0] i,
                                           input logic [7:0] a, input logic [7:0] d,
                                           input logic w);
    host_state_t r;
    r              = s;
    r.step_addr[i] = a;
    r.step_data[i] = d;
    r.step_wr[i]   = w;
    return r;
  endfunction

  logic busy;
  logic cmd_accept;
  assign busy       = (state_reg.phase != PH_IDLE);
  assign cmd_accept = avs_write_i && !busy && (avs_address_i == radio_pkg::HOST_COMMAND_OFS);

  always_comb begin
    logic        c_wr;
    logic [7:0]  c_addr;
    logic [7:0]  c_data;
    logic [7:0]  mid;
    logic [31:0] stat;
    c_wr   = avs_writedata_i[radio_pkg::CMD_WRITE_BIT];
    c_addr = avs_writedata_i[radio_pkg::CMD_ADDR_LSB +: 8];
    c_data = avs_writedata_i[radio_pkg::CMD_DATA_LSB +: 8];
    mid    = 8'h00;
    stat   = 32'h0000_0000;
    state_next = state_reg;
    state_next.bus_wr = 1'b0;
    state_next.bus_rd = 1'b0;

    // avalon reads take two edges so read data leaves a flip-flop
    state_next.rd_ack = avs_read_i && !state_reg.rd_ack;
    if (avs_read_i && !state_reg.rd_ack) begin
      stat[radio_pkg::STAT_BUSY_BIT]          = busy;
      stat[radio_pkg::STAT_CHAN_DONE_BIT]     = state_reg.chan_done;
      stat[radio_pkg::STAT_CHAN_ERR_BIT]      = state_reg.chan_error;
      stat[radio_pkg::STAT_RDATA_LSB +: 8]    = state_reg.last_rdata;
      state_next.readdata = (avs_address_i == radio_pkg::HOST_STATUS_OFS) ? stat : 32'h0000_0000;
    end

    if (cmd_accept) begin
      state_next.chan_error = 1'b0;
      state_next.step_idx   = 2'h0;
      state_next.step_last  = 2'h0;
      state_next.phase      = PH_ISSUE;
      if (c_wr && c_addr == radio_pkg::ANALOG_CONTROL_OFS) begin
        c_data = c_data & radio_pkg::ANALOG_WRITABLE_MASK;
        if (c_data[radio_pkg::SOFT_RESET_BIT]) begin
          state_next = put_step(state_next, 2'h0, c_addr, c_data, 1'b1);
          state_next.analog_shadow = radio_pkg::ANALOG_CONTROL_RESET;
          state_next.chan_done     = 1'b0;
        end else begin
          mid = c_data;
          // turning on: polarity first; turning off: enable first
          if (state_reg.analog_shadow[radio_pkg::AMP_ENABLE_BIT]) begin
            mid[radio_pkg::AMP_POL_BIT] = state_reg.analog_shadow[radio_pkg::AMP_POL_BIT];
          end else begin
            mid[radio_pkg::AMP_ENABLE_BIT] = state_reg.analog_shadow[radio_pkg::AMP_ENABLE_BIT];
          end
          state_next = put_step(state_next, 2'h0, c_addr, mid, 1'b1);
          if (mid != c_data) begin
            state_next = put_step(state_next, 2'h1, c_addr, c_data, 1'b1);
            state_next.step_last = 2'h1;
          end
          state_next.analog_shadow = c_data & radio_pkg::ANALOG_STORED_MASK;
        end
      end else if (c_wr && c_addr == radio_pkg::CHANNEL_SELECT_OFS) begin
        c_data = c_data & radio_pkg::CHANNEL_WRITABLE_MASK;
        if (c_data[6:0] < radio_pkg::CHANNEL_MIN || c_data[6:0] > radio_pkg::CHANNEL_MAX) begin
          state_next.chan_error = 1'b1;
          state_next.phase      = PH_IDLE;
        end else begin
          state_next = put_step(state_next, 2'h0, c_addr, c_data, 1'b1);
          state_next.chan_done = 1'b1;
        end
      end else if (!c_wr && radio_pkg::in_id_range(c_addr)) begin
        // identifier enable is raised around the one read, then dropped
        mid = state_reg.analog_shadow;
        mid[radio_pkg::ID_ENABLE_BIT] = 1'b1;
        state_next = put_step(state_next, 2'h0, radio_pkg::ANALOG_CONTROL_OFS, mid, 1'b1);
        state_next = put_step(state_next, 2'h1, c_addr, 8'h00, 1'b0);
        mid[radio_pkg::ID_ENABLE_BIT] = 1'b0;
        state_next = put_step(state_next, 2'h2, radio_pkg::ANALOG_CONTROL_OFS, mid, 1'b1);
        state_next.step_last     = 2'h2;
        state_next.analog_shadow = mid;
      end else begin
        state_next = put_step(state_next, 2'h0, c_addr, c_wr ? c_data : 8'h00, c_wr);
      end
    end

    case (state_reg.phase)
      PH_IDLE: begin
      end
      PH_ISSUE: begin
        state_next.bus_addr  = state_reg.step_addr[state_reg.step_idx];
        state_next.bus_wdata = state_reg.step_data[state_reg.step_idx];
        state_next.bus_wr    = state_reg.step_wr[state_reg.step_idx];
        state_next.bus_rd    = !state_reg.step_wr[state_reg.step_idx];
        state_next.phase     = PH_WAIT;
      end
      PH_WAIT: begin
        if (state_reg.step_wr[state_reg.step_idx] || bus.rvalid) begin
          if (!state_reg.step_wr[state_reg.step_idx]) begin
            state_next.last_rdata = bus.rdata;
          end
          if (state_reg.step_idx == state_reg.step_last) begin
            state_next.phase = PH_IDLE;
          end else begin
            state_next.step_idx = state_reg.step_idx + 2'h1;
            state_next.phase    = PH_ISSUE;
          end
        end
      end
      default: begin
        state_next.phase = PH_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // a command write stalls while a sequence is still running
  assign avs_waitrequest_o = (avs_read_i && !state_reg.rd_ack) ||
                             (avs_write_i && busy && (avs_address_i == radio_pkg::HOST_COMMAND_OFS));
  assign avs_readdata_o    = state_reg.readdata;
  assign tx_permit_o       = state_reg.chan_done;
  assign bus.addr          = state_reg.bus_addr;
  assign bus.wdata         = state_reg.bus_wdata;
  assign bus.wr            = state_reg.bus_wr;
  assign bus.rd            = state_reg.bus_rd;

endmodule

/* File: radio_bus_sva.sv */
// assertions on the register port between host controller and radio bank
`timescale 1ns/10ps
module radio_bus_sva (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [7:0]  addr,
  input wire logic [7:0]  wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [7:0]  rdata,
  input wire logic        rvalid,
  input wire logic        amp_request_i,
  input wire logic        amp_control_pin_o,
  input wire logic        soft_reset_o,
  input wire logic [6:0]  channel_o,
  input wire logic [11:0] freq_mhz_o,
  input wire logic [7:0]  gated_lo_o
);
  // shadow of stored analog_control bits, rebuilt from port traffic only
  logic [7:0] ana_reg;
  logic       wr_ana;
  assign wr_ana = wr && (addr == 8'h20);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ana_reg <= 8'h00;
    end else if (wr_ana) begin
      ana_reg <= wdata[0] ? 8'h00 : (wdata & 8'h66);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  rd_answer_a: assert property (rd |=> rvalid)
    else $error("read not answered");
  id_hidden_a: assert property (rd && addr[7:2] == 6'h0f && !ana_reg[5] |=> rdata == 8'h00)
    else $error("identifier readable while disabled");
  rsvd_zero_a: assert property (rd && addr == 8'h20 |=> (rdata & 8'h99) == 8'h00)
    else $error("reserved bits not zero");
  chan_rsvd_a: assert property (rd && addr == 8'h21 |=> !rdata[7])
    else $error("channel bit 7 not zero");
  soft_pulse_a: assert property (wr_ana && wdata[0] |=> soft_reset_o ##1 !soft_reset_o)
    else $error("soft reset pulse wrong");
  soft_clear_a: assert property (soft_reset_o |-> channel_o == 7'h00 && freq_mhz_o == 12'h960)
    else $error("soft reset left state");
  chan_freq_a: assert property (wr && addr == 8'h21 |=>
    channel_o == $past(wdata[6:0]) && freq_mhz_o == 12'h960 + {5'h00, $past(wdata[6:0])})
    else $error("channel frequency wrong");
  gate_shut_a: assert property (wr && addr == 8'h2e && !ana_reg[6] |=> $stable(gated_lo_o))
    else $error("gated register written while locked");
  gate_open_a: assert property (wr && addr == 8'h2e && ana_reg[6] |=> gated_lo_o == $past(wdata))
    else $error("gated register not written");
  // the pin flop already uses the bits landing with the same write, so no lag on them
  amp_pin_a: assert property (amp_control_pin_o ==
    (ana_reg[2] ? ($past(amp_request_i) ^ ana_reg[1]) : 1'b0))
    else $error("amp pin level wrong");
  cover property (soft_reset_o);
  cover property (wr && addr == 8'h2e && ana_reg[6]);
  cover property (rd && addr == 8'h3f && ana_reg[5]);
  cover property (amp_control_pin_o && ana_reg[1]);
endmodule

/* File: tb.sv */
// self-checking bench: host controller and radio bank across their port
`timescale 1ns/10ps
module tb;
  typedef struct packed { logic [31:0] val; logic [31:0] mask; } note_t;
  logic        clk_i, resetn_i, avs_read_i, avs_write_i, avs_waitrequest_o;
  logic [3:0]  avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd_last;
  logic        tx_permit_o, amp_request_i, amp_control_pin_o, amp_control_pin_oe_o;
  logic        id_power_o, soft_reset_o;
  logic [29:0] id_word_i;
  logic [6:0]  channel_o, ch;
  logic [11:0] freq_mhz_o;
  logic [7:0]  gated_lo_o, gated_hi_o;
  logic [7:0]  bad_ch [4] = '{8'h00, 8'h01, 8'h50, 8'h7f};
  logic [7:0]  amp_seq [4] = '{8'h04, 8'h06, 8'h00, 8'h06};
  note_t       note_q[$];
  note_t       nt;
  int          num_errors, n_checks;
  integer      seed;

  radio_reg_if u_radio_reg_if ();
  radio_regs u_radio_regs (.clk_i(clk_i), .resetn_i(resetn_i), .bus(u_radio_reg_if),
    .id_word_i(id_word_i), .amp_request_i(amp_request_i),
    .amp_control_pin_o(amp_control_pin_o), .amp_control_pin_oe_o(amp_control_pin_oe_o),
    .id_power_o(id_power_o), .soft_reset_o(soft_reset_o), .channel_o(channel_o),
    .freq_mhz_o(freq_mhz_o), .gated_lo_o(gated_lo_o), .gated_hi_o(gated_hi_o));
  radio_host u_radio_host (.clk_i(clk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .tx_permit_o(tx_permit_o),
    .bus(u_radio_reg_if));
  radio_bus_sva u_radio_bus_sva (.clk_i(clk_i), .resetn_i(resetn_i),
    .addr(u_radio_reg_if.addr), .wdata(u_radio_reg_if.wdata), .wr(u_radio_reg_if.wr),
    .rd(u_radio_reg_if.rd), .rdata(u_radio_reg_if.rdata), .rvalid(u_radio_reg_if.rvalid),
    .amp_request_i(amp_request_i), .amp_control_pin_o(amp_control_pin_o),
    .soft_reset_o(soft_reset_o), .channel_o(channel_o), .freq_mhz_o(freq_mhz_o),
    .gated_lo_o(gated_lo_o));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest is seen low
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 100);
    if (n >= 100) num_errors++;
    rd_last = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    note_q.push_back('{e, m});
    av(a, 1'b0, 32'h0);
  endtask

  // device access through the host; polls busy, then lets outputs settle
  task automatic cmd(input logic [7:0] a, input logic [7:0] d, input logic w);
    int n = 0;
    av(4'h0, 1'b1, {15'h0, w, d, a});
    do begin
      rd(4'h4, 32'h0, 32'h0);
      n++;
    end while (rd_last[0] !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    @(negedge clk_i);
  endtask

  task automatic devrd(input logic [7:0] a, input logic [7:0] e);
    cmd(a, 8'h00, 1'b0);
    rd(4'h4, {16'h0, e, 8'h0}, 32'hff00);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // read results are paired with the oldest note
  always @(posedge clk_i) begin
    if (resetn_i && avs_read_i && avs_waitrequest_o === 1'b0) begin
      if (note_q.size() == 0) num_errors++;
      else begin
        nt = note_q.pop_front();
        cmp(avs_readdata_o & nt.mask, nt.val & nt.mask);
      end
    end
  end

  always @(posedge clk_i) amp_request_i <= 1'($random(seed));

  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    complete_run();
  end

  initial begin
    seed = 32'hed4f;
    resetn_i = 1'b0;
    avs_address_i = 4'h0;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    amp_request_i = 1'b0;
    id_word_i = 30'($random(seed));
    repeat (5) @(posedge clk_i);
    resetn_i <= 1'b1;
    devrd(8'h20, 8'h00);
    devrd(8'h21, 8'h00);
    rd(4'h8, 32'h0, 32'hffffffff);
    foreach (bad_ch[i]) begin
      cmd(8'h21, bad_ch[i], 1'b1);
      cmp(32'(channel_o), 32'h0);
      cmp(32'(tx_permit_o), 32'h0);
      rd(4'h4, 32'h4, 32'h6);
    end
    for (int i = 0; i < 12; i++) begin
      ch = (i == 0) ? 7'h02 : (i == 1) ? 7'h4f : 7'(2 + ({$random(seed)} % 78));
      cmd(8'h21, {1'b0, ch}, 1'b1);
      cmp(32'(freq_mhz_o), 32'(12'd2400 + ch));
      cmp(32'(tx_permit_o), 32'h1);
      devrd(8'h21, {1'b0, ch});
    end
    cmd(8'h2e, 8'ha5, 1'b1);
    cmp(32'(gated_lo_o), 32'h0);
    cmd(8'h20, 8'h40, 1'b1);
    cmd(8'h2e, 8'ha5, 1'b1);
    cmd(8'h2f, 8'h5a, 1'b1);
    cmp(32'({gated_hi_o, gated_lo_o}), 32'h5aa5);
    // the host always raises the identifier enable around its own read
    devrd(8'h3c, id_word_i[7:0]);
    cmp(32'(id_power_o), 32'h0);
    cmd(8'h20, 8'h20, 1'b1);
    cmp(32'(id_power_o), 32'h1);
    for (int i = 0; i < 4; i++)
      devrd(8'(8'h3c + i), 8'({2'b00, id_word_i} >> (8 * i)));
    cmd(8'h20, 8'h00, 1'b1);
    cmp(32'(id_power_o), 32'h0);
    // both amp bits moving together must be split by the host
    foreach (amp_seq[i]) begin
      cmd(8'h20, amp_seq[i], 1'b1);
      cmp(32'(amp_control_pin_oe_o), 32'(i != 2));
    end
    repeat (20) @(posedge clk_i);
    devrd(8'h20, 8'h06);
    cmd(8'h20, 8'hfe, 1'b1);
    devrd(8'h20, 8'h66);
    cmd(8'h21, 8'h10, 1'b1);
    cmd(8'h20, 8'h45, 1'b1);
    cmp(32'({tx_permit_o, channel_o, freq_mhz_o}), 32'h00960);
    cmp(32'({amp_control_pin_oe_o, id_power_o, gated_lo_o}), 32'h0);
    devrd(8'h20, 8'h00);
    complete_run();
  end
endmodule
